// File: hw/chsla_params.svh
`ifndef CHSLA_PARAMS_SVH
`define CHSLA_PARAMS_SVH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define CHSLA_OFS_PHASE 8'h34
`define CHSLA_OFS_LOOP 8'h35
`define CHSLA_OFS_EVENT 8'h36

// ----------------------------------------
// widths and reset values
// ----------------------------------------
`define CHSLA_CMD_W 8
`define CHSLA_DATA_W 16
`define CHSLA_PHASE_W 13
`define CHSLA_LOOP_W 6
`define CHSLA_EVENT_W 16
`define CHSLA_MEAS_W 16
`define CHSLA_PHASE_RST 13'h0100
`define CHSLA_LOOP_RST 6'h00
`define CHSLA_EVENT_RST 16'h0000

// ----------------------------------------
// charging phase codes, one hot
// ----------------------------------------
`define CHSLA_PH_DETECT_FAIL 13'h1000
`define CHSLA_PH_DETECTING 13'h0800
`define CHSLA_PH_ABSORB 13'h0200
`define CHSLA_PH_SUSPENDED 13'h0100
`define CHSLA_PH_NORMAL 13'h0040
`define CHSLA_PH_THERMAL_PAUSE 13'h0020
`define CHSLA_PH_TIMER_DONE 13'h0010
`define CHSLA_PH_TAPER_DONE 13'h0008
`define CHSLA_PH_TIMEOUT 13'h0004
`define CHSLA_PH_BAT_MISSING 13'h0002
`define CHSLA_PH_BAT_SHORT 13'h0001
`define CHSLA_LOOP_INPUT_LIMIT 6'h20

// ----------------------------------------
// event register field positions
// ----------------------------------------
`define CHSLA_EV_TELEM 15
`define CHSLA_EV_SERIES_DONE 14
`define CHSLA_EV_CELL_UNDER 11
`define CHSLA_EV_CELL_OVER 10
`define CHSLA_EV_IN_UNDER 9
`define CHSLA_EV_IN_OVER 8
`define CHSLA_EV_OUT_UNDER 7
`define CHSLA_EV_OUT_OVER 6
`define CHSLA_EV_IN_I_OVER 5
`define CHSLA_EV_CELL_I_UNDER 4
`define CHSLA_EV_CHIP_T_OVER 3
`define CHSLA_EV_SERIES_OVER 2
`define CHSLA_EV_SENSOR_OVER 1
`define CHSLA_EV_SENSOR_UNDER 0
`define CHSLA_EV_IMPL_MASK 16'hcfff
`define CHSLA_CMP_N 12
`define CHSLA_CMP_ABOVE 12'h56e

`endif

// File: hw/chsla_pkg.sv
`default_nettype none
`include "chsla_params.svh"

package chsla_pkg;

  // ----------------------------------------
  // charging phase reported by the charger
  // ----------------------------------------
  typedef enum logic [3:0] {
    ph_detect_fail,
    ph_detecting,
    ph_absorb,
    ph_suspended,
    ph_normal_charging,
    ph_thermal_pause,
    ph_timer_done,
    ph_taper_done,
    ph_charge_timeout,
    ph_battery_missing,
    ph_battery_short
  } chsla_phase_t;

  // ----------------------------------------
  // decoded serial port word access
  // ----------------------------------------
  typedef struct packed {
    logic [`CHSLA_CMD_W-1:0] cmd;
    logic wr;
    logic rd;
    logic [`CHSLA_DATA_W-1:0] wdata;
  } chsla_req_t;

  // ----------------------------------------
  // telemetry results and limits
  // ----------------------------------------
  typedef struct packed {
    logic signed [`CHSLA_MEAS_W-1:0] cell_v;
    logic signed [`CHSLA_MEAS_W-1:0] in_v;
    logic signed [`CHSLA_MEAS_W-1:0] out_v;
    logic signed [`CHSLA_MEAS_W-1:0] in_i;
    logic signed [`CHSLA_MEAS_W-1:0] cell_i;
    logic signed [`CHSLA_MEAS_W-1:0] chip_t;
    logic signed [`CHSLA_MEAS_W-1:0] series_r;
    logic signed [`CHSLA_MEAS_W-1:0] sensor_v;
  } chsla_meas_t;

  typedef struct packed {
    logic signed [`CHSLA_MEAS_W-1:0] cell_v_lo;
    logic signed [`CHSLA_MEAS_W-1:0] cell_v_hi;
    logic signed [`CHSLA_MEAS_W-1:0] in_v_lo;
    logic signed [`CHSLA_MEAS_W-1:0] in_v_hi;
    logic signed [`CHSLA_MEAS_W-1:0] out_v_lo;
    logic signed [`CHSLA_MEAS_W-1:0] out_v_hi;
    logic signed [`CHSLA_MEAS_W-1:0] in_i_hi;
    logic signed [`CHSLA_MEAS_W-1:0] cell_i_lo;
    logic signed [`CHSLA_MEAS_W-1:0] chip_t_hi;
    logic signed [`CHSLA_MEAS_W-1:0] series_r_hi;
    logic signed [`CHSLA_MEAS_W-1:0] sensor_v_hi;
    logic signed [`CHSLA_MEAS_W-1:0] sensor_v_lo;
  } chsla_limit_t;

endpackage

`default_nettype wire

// File: hw/chsla_limit_cmp.sv
`timescale 1ns/1ns
`default_nettype none

module chsla_limit_cmp #(
  parameter int W = 16,
  parameter bit ABOVE = 1'b1
) (
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic i_stb,
  input wire logic signed [W-1:0] i_value,
  input wire logic signed [W-1:0] i_limit,
  output logic o_hit
);

  logic hit_reg;
  logic hit_next;

  // ----------------------------------------
  // one comparison per fresh sample
  // ----------------------------------------
  always_comb begin
    if (ABOVE) begin
      hit_next = i_stb && (i_value > i_limit);
    end else begin
      hit_next = i_stb && (i_value < i_limit);
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      hit_reg <= 1'h0;
    end else begin
      hit_reg <= hit_next;
    end
  end

  assign o_hit = hit_reg;

endmodule // chsla_limit_cmp

`default_nettype wire

// File: hw/chsla_sticky_flags.sv
`timescale 1ns/1ns
`default_nettype none

module chsla_sticky_flags #(
  parameter int W = 16,
  parameter logic [W-1:0] IMPL = '1
) (
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic [W-1:0] i_set,
  input wire logic [W-1:0] i_clear,
  input wire logic [W-1:0] i_enable,
  output logic [W-1:0] o_flags
);

  logic [W-1:0] flags_reg;
  logic [W-1:0] flags_next;

  // ----------------------------------------
  // set beats write clear, disable beats all
  // ----------------------------------------
  always_comb begin
    flags_next = ((flags_reg & ~i_clear) | i_set) & i_enable & IMPL;
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      flags_reg <= '0;
    end else begin
      flags_reg <= flags_next;
    end
  end

  assign o_flags = flags_reg;

endmodule // chsla_sticky_flags

`default_nettype wire

// File: hw/chsla_core.sv
`timescale 1ns/1ns
`default_nettype none
`include "chsla_params.svh"


module chsla_core
  import chsla_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_srst,
  input wire chsla_req_t i_req,
  output logic [`CHSLA_DATA_W-1:0] o_rdata,
  output logic o_rd_valid,
  input wire chsla_phase_t i_phase,
  input wire logic [`CHSLA_LOOP_W-1:0] i_loop_flags,
  input wire chsla_meas_t i_meas,
  input wire logic i_meas_stb,
  input wire chsla_limit_t i_limit,
  input wire logic [`CHSLA_EVENT_W-1:0] i_alert_en,
  input wire logic i_telem_ready,
  input wire logic i_series_done,
  output logic [`CHSLA_PHASE_W-1:0] o_phase_word,
  output logic [`CHSLA_LOOP_W-1:0] o_loop_flags,
  output logic [`CHSLA_EVENT_W-1:0] o_event_flags
);

  localparam int CmpN = `CHSLA_CMP_N;
  localparam logic [CmpN-1:0] CmpAbove = `CHSLA_CMP_ABOVE;

  logic [`CHSLA_PHASE_W-1:0] phase_reg;
  logic [`CHSLA_PHASE_W-1:0] phase_next;
  logic [`CHSLA_LOOP_W-1:0] loop_reg;
  logic [`CHSLA_LOOP_W-1:0] loop_next;
  logic charging;
  logic [`CHSLA_DATA_W-1:0] rdata_reg;
  logic [`CHSLA_DATA_W-1:0] rdata_next;
  logic rd_valid_reg;
  logic rd_valid_next;
  logic [`CHSLA_EVENT_W-1:0] ev_flags;
  logic [`CHSLA_EVENT_W-1:0] ev_set;
  logic [`CHSLA_EVENT_W-1:0] ev_clear;
  logic ev_write;
  logic [CmpN-1:0] cmp_hit;
  logic signed [`CHSLA_MEAS_W-1:0] cmp_val [CmpN];
  logic signed [`CHSLA_MEAS_W-1:0] cmp_lim [CmpN];

  // ----------------------------------------
  // charging phase word
  // ----------------------------------------
  always_comb begin
    phase_next = phase_reg;
    unique case (i_phase)
      ph_detect_fail: phase_next = `CHSLA_PH_DETECT_FAIL;
      ph_detecting: phase_next = `CHSLA_PH_DETECTING;
      ph_absorb: phase_next = `CHSLA_PH_ABSORB;
      ph_suspended: phase_next = `CHSLA_PH_SUSPENDED;
      ph_normal_charging: phase_next = `CHSLA_PH_NORMAL;
      ph_thermal_pause: phase_next = `CHSLA_PH_THERMAL_PAUSE;
      ph_timer_done: phase_next = `CHSLA_PH_TIMER_DONE;
      ph_taper_done: phase_next = `CHSLA_PH_TAPER_DONE;
      ph_charge_timeout: phase_next = `CHSLA_PH_TIMEOUT;
      ph_battery_missing: phase_next = `CHSLA_PH_BAT_MISSING;
      ph_battery_short: phase_next = `CHSLA_PH_BAT_SHORT;
      default: phase_next = phase_reg;
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      phase_reg <= `CHSLA_PHASE_RST;
    end else begin
      phase_reg <= phase_next;
    end
  end

  // ----------------------------------------
  // regulation loop flags
  // ----------------------------------------
  always_comb begin
    charging = (phase_next == `CHSLA_PH_NORMAL) || (phase_next == `CHSLA_PH_ABSORB);
    loop_next = '0;
    if (charging) begin
      // keep only the highest active loop
      for (int b = 0; b < `CHSLA_LOOP_W; b++) begin
        if (i_loop_flags[b]) begin
          loop_next = '0;
          loop_next[b] = 1'h1;
        end
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      loop_reg <= `CHSLA_LOOP_RST;
    end else begin
      loop_reg <= loop_next;
    end
  end

  // ----------------------------------------
  // limit comparisons
  // ----------------------------------------
  always_comb begin
    cmp_val[`CHSLA_EV_CELL_UNDER] = i_meas.cell_v;
    cmp_lim[`CHSLA_EV_CELL_UNDER] = i_limit.cell_v_lo;
    cmp_val[`CHSLA_EV_CELL_OVER] = i_meas.cell_v;
    cmp_lim[`CHSLA_EV_CELL_OVER] = i_limit.cell_v_hi;
    cmp_val[`CHSLA_EV_IN_UNDER] = i_meas.in_v;
    cmp_lim[`CHSLA_EV_IN_UNDER] = i_limit.in_v_lo;
    cmp_val[`CHSLA_EV_IN_OVER] = i_meas.in_v;
    cmp_lim[`CHSLA_EV_IN_OVER] = i_limit.in_v_hi;
    cmp_val[`CHSLA_EV_OUT_UNDER] = i_meas.out_v;
    cmp_lim[`CHSLA_EV_OUT_UNDER] = i_limit.out_v_lo;
    cmp_val[`CHSLA_EV_OUT_OVER] = i_meas.out_v;
    cmp_lim[`CHSLA_EV_OUT_OVER] = i_limit.out_v_hi;
    cmp_val[`CHSLA_EV_IN_I_OVER] = i_meas.in_i;
    cmp_lim[`CHSLA_EV_IN_I_OVER] = i_limit.in_i_hi;
    cmp_val[`CHSLA_EV_CELL_I_UNDER] = i_meas.cell_i;
    cmp_lim[`CHSLA_EV_CELL_I_UNDER] = i_limit.cell_i_lo;
    cmp_val[`CHSLA_EV_CHIP_T_OVER] = i_meas.chip_t;
    cmp_lim[`CHSLA_EV_CHIP_T_OVER] = i_limit.chip_t_hi;
    cmp_val[`CHSLA_EV_SERIES_OVER] = i_meas.series_r;
    cmp_lim[`CHSLA_EV_SERIES_OVER] = i_limit.series_r_hi;
    cmp_val[`CHSLA_EV_SENSOR_OVER] = i_meas.sensor_v;
    cmp_lim[`CHSLA_EV_SENSOR_OVER] = i_limit.sensor_v_hi;
    cmp_val[`CHSLA_EV_SENSOR_UNDER] = i_meas.sensor_v;
    cmp_lim[`CHSLA_EV_SENSOR_UNDER] = i_limit.sensor_v_lo;
  end

  for (genvar k = 0; k < CmpN; k++) begin : g_cmp
    chsla_limit_cmp #(
      .W(`CHSLA_MEAS_W),
      .ABOVE(CmpAbove[k])
    ) u_cmp (
      .i_clk(i_clk),
      .i_srst(i_srst),
      .i_stb(i_meas_stb),
      .i_value(cmp_val[k]),
      .i_limit(cmp_lim[k]),
      .o_hit(cmp_hit[k])
    );
  end

  // ----------------------------------------
  // threshold event register
  // ----------------------------------------
  always_comb begin
    ev_write = i_req.wr && (i_req.cmd == `CHSLA_OFS_EVENT);
    ev_clear = ev_write ? ~i_req.wdata : '0;
    ev_set = '0;
    ev_set[CmpN-1:0] = cmp_hit;
    ev_set[`CHSLA_EV_TELEM] = i_telem_ready;
    ev_set[`CHSLA_EV_SERIES_DONE] = i_series_done;
  end

  chsla_sticky_flags #(
    .W(`CHSLA_EVENT_W),
    .IMPL(`CHSLA_EV_IMPL_MASK)
  ) u_events (
    .i_clk(i_clk),
    .i_srst(i_srst),
    .i_set(ev_set),
    .i_clear(ev_clear),
    .i_enable(i_alert_en),
    .o_flags(ev_flags)
  );

  // ----------------------------------------
  // read-back port
  // ----------------------------------------
  always_comb begin
    rd_valid_next = i_req.rd;
    rdata_next = rdata_reg;
    if (i_req.rd) begin
      unique case (i_req.cmd)
        `CHSLA_OFS_PHASE: rdata_next = {3'h0, phase_reg};
        `CHSLA_OFS_LOOP: rdata_next = {10'h000, loop_reg};
        `CHSLA_OFS_EVENT: rdata_next = ev_flags;
        default: rdata_next = '0;
      endcase
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      rdata_reg <= '0;
      rd_valid_reg <= 1'h0;
    end else begin
      rdata_reg <= rdata_next;
      rd_valid_reg <= rd_valid_next;
    end
  end

  assign o_rdata = rdata_reg;
  assign o_rd_valid = rd_valid_reg;
  assign o_phase_word = phase_reg;
  assign o_loop_flags = loop_reg;
  assign o_event_flags = ev_flags;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_srst);

  sequence s_ev_write;
    i_req.wr && (i_req.cmd == `CHSLA_OFS_EVENT);
  endsequence

  sequence s_cell_under;
    i_meas_stb && (i_meas.cell_v < i_limit.cell_v_lo)
      ##1 i_alert_en[`CHSLA_EV_CELL_UNDER];
  endsequence

  sequence s_in_over;
    i_meas_stb && (i_meas.in_v > i_limit.in_v_hi)
      ##1 i_alert_en[`CHSLA_EV_IN_OVER];
  endsequence

  sequence s_out_under;
    i_meas_stb && (i_meas.out_v < i_limit.out_v_lo)
      ##1 i_alert_en[`CHSLA_EV_OUT_UNDER];
  endsequence

  sequence s_in_i_over;
    i_meas_stb && (i_meas.in_i > i_limit.in_i_hi)
      ##1 i_alert_en[`CHSLA_EV_IN_I_OVER];
  endsequence

  sequence s_chip_t_over;
    i_meas_stb && (i_meas.chip_t > i_limit.chip_t_hi)
      ##1 i_alert_en[`CHSLA_EV_CHIP_T_OVER];
  endsequence

  sequence s_sensor_under;
    i_meas_stb && (i_meas.sensor_v < i_limit.sensor_v_lo)
      ##1 i_alert_en[`CHSLA_EV_SENSOR_UNDER];
  endsequence

  phase_onehot_a: assert property ($onehot(phase_reg))
    else $error("phase word not one hot");

  phase_reset_a: assert property ($fell(i_srst) |-> phase_reg == `CHSLA_PHASE_RST)
    else $error("phase word reset value wrong");

  phase_normal_a: assert property (
    i_phase == ph_normal_charging |=> phase_reg == `CHSLA_PH_NORMAL)
    else $error("normal charging phase bit wrong");

  phase_fail_a: assert property (
    i_phase == ph_detect_fail |=> phase_reg == `CHSLA_PH_DETECT_FAIL)
    else $error("detect fail phase bit wrong");

  loop_exclusive_a: assert property ($onehot0(loop_reg))
    else $error("loop flags not exclusive");

  loop_charging_a: assert property (
    loop_reg != '0 |-> (phase_reg & (`CHSLA_PH_NORMAL | `CHSLA_PH_ABSORB)) != '0)
    else $error("loop flag outside charging");

  loop_follow_a: assert property (
    i_phase == ph_normal_charging && i_loop_flags == `CHSLA_LOOP_INPUT_LIMIT
      |=> loop_reg == `CHSLA_LOOP_INPUT_LIMIT)
    else $error("input limit loop flag not reported");

  event_cause_a: assert property (
    ((ev_flags & ~$past(ev_flags)) & ~$past(ev_set)) == '0)
    else $error("event bit set without cause");

  event_disable_a: assert property ((ev_flags & ~$past(i_alert_en)) == '0)
    else $error("disabled event bit still set");

  write_clear_a: assert property (
    s_ev_write |=> (ev_flags & ~$past(i_req.wdata) & ~$past(ev_set)) == '0)
    else $error("written zero did not clear");

  event_hold_a: assert property (
    $past(i_srst) || (($past(ev_flags) & $past(i_alert_en) & ~$past(ev_clear)) & ~ev_flags) == '0)
    else $error("event bit dropped on its own");

  reserved_zero_a: assert property (ev_flags[13:12] == 2'h0)
    else $error("reserved event bits set");

  telem_set_a: assert property (
    i_telem_ready && i_alert_en[`CHSLA_EV_TELEM] |=> ev_flags[`CHSLA_EV_TELEM])
    else $error("telemetry ready event missed");

  series_set_a: assert property (
    i_series_done && i_alert_en[`CHSLA_EV_SERIES_DONE]
      |=> ev_flags[`CHSLA_EV_SERIES_DONE])
    else $error("resistance done event missed");

  cell_under_a: assert property (s_cell_under |=> ev_flags[`CHSLA_EV_CELL_UNDER])
    else $error("cell under event missed");

  in_over_a: assert property (s_in_over |=> ev_flags[`CHSLA_EV_IN_OVER])
    else $error("input over event missed");

  out_under_a: assert property (s_out_under |=> ev_flags[`CHSLA_EV_OUT_UNDER])
    else $error("output under event missed");

  in_i_over_a: assert property (s_in_i_over |=> ev_flags[`CHSLA_EV_IN_I_OVER])
    else $error("input current event missed");

  chip_t_over_a: assert property (
    s_chip_t_over |=> ev_flags[`CHSLA_EV_CHIP_T_OVER])
    else $error("chip temperature event missed");

  sensor_under_a: assert property (
    s_sensor_under |=> ev_flags[`CHSLA_EV_SENSOR_UNDER])
    else $error("sensor under event missed");

  read_answer_a: assert property (i_req.rd |=> o_rd_valid ##1 !o_rd_valid || $past(i_req.rd))
    else $error("read answer timing wrong");

endmodule // chsla_core

`default_nettype wire

// File: testbench/chsla_host_model.sv
`timescale 1ns/1ns
`default_nettype none

module chsla_host_model
  import chsla_pkg::*;
(
  input wire logic i_clk,
  input wire logic [15:0] i_rdata,
  input wire logic i_rd_valid,
  output chsla_req_t o_req
);
  initial begin
    o_req = '0;
  end

  // ----------------------------------------
  // released cmd and wdata lines show inverse of last value, rd and wr go low
  // ----------------------------------------
  task automatic release_bus();
    o_req.rd = 1'b0;
    o_req.wr = 1'b0;
    o_req.cmd = ~o_req.cmd;
    o_req.wdata = ~o_req.wdata;
  endtask

  task automatic wr(input logic [7:0] cmd, input logic [15:0] data);
    @(posedge i_clk);
    #1;
    o_req.cmd = cmd;
    o_req.wdata = data;
    o_req.wr = 1'b1;
    @(posedge i_clk);
    #1;
    release_bus();
  endtask

  // answer expected just after the edge that takes the request
  task automatic rd(input logic [7:0] cmd, output logic [15:0] data, output bit ok);
    ok = 1'b0;
    data = 'x;
    @(posedge i_clk);
    #1;
    o_req.cmd = cmd;
    o_req.rd = 1'b1;
    @(posedge i_clk);
    #1;
    release_bus();
    if (i_rd_valid === 1'b1) begin
      ok = 1'b1;
      data = i_rdata;
    end
  endtask
endmodule // chsla_host_model

`default_nettype wire

// File: testbench/charger_state_and_limit_alerts_tb.sv
`timescale 1ns/1ns
`default_nettype none
`include "chsla_params.svh"

module charger_state_and_limit_alerts_tb
  import chsla_pkg::*;
;
  logic clk = 1'b0;
  logic srst = 1'b1;
  chsla_req_t req;
  logic [15:0] rdata;
  logic rd_valid;
  chsla_phase_t phase = ph_suspended;
  logic [5:0] loop_in = 6'h00;
  chsla_meas_t meas = '0;
  logic meas_stb = 1'b0;
  chsla_limit_t lim = '0;
  logic [15:0] alert_en = 16'h0000;
  logic telem = 1'b0;
  logic series = 1'b0;
  logic [12:0] phase_word;
  logic [5:0] loop_out;
  logic [15:0] event_out;
  int error_cnt = 0;
  int compares = 0;
  localparam logic [12:0] CODES [11] = '{`CHSLA_PH_DETECT_FAIL, `CHSLA_PH_DETECTING,
    `CHSLA_PH_ABSORB, `CHSLA_PH_SUSPENDED, `CHSLA_PH_NORMAL, `CHSLA_PH_THERMAL_PAUSE,
    `CHSLA_PH_TIMER_DONE, `CHSLA_PH_TAPER_DONE, `CHSLA_PH_TIMEOUT, `CHSLA_PH_BAT_MISSING,
    `CHSLA_PH_BAT_SHORT};
  localparam int MPOS [12] = '{0, 0, 1, 2, 3, 4, 5, 5, 6, 6, 7, 7};
  localparam logic [11:0] ABOVE = 12'h056e;

  initial begin
    forever #50 clk = ~clk;
  end

  chsla_core DUT (.i_clk(clk), .i_srst(srst), .i_req(req), .o_rdata(rdata),
    .o_rd_valid(rd_valid), .i_phase(phase), .i_loop_flags(loop_in), .i_meas(meas),
    .i_meas_stb(meas_stb), .i_limit(lim), .i_alert_en(alert_en), .i_telem_ready(telem),
    .i_series_done(series), .o_phase_word(phase_word), .o_loop_flags(loop_out),
    .o_event_flags(event_out));

  chsla_host_model host (.i_clk(clk), .i_rdata(rdata), .i_rd_valid(rd_valid), .o_req(req));

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic tick();
    @(posedge clk);
    #1;
  endtask

  task automatic check16(input string what, input logic [15:0] exp, input logic [15:0] got);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic rd_chk(input logic [7:0] cmd, input logic [15:0] exp, input string what);
    logic [15:0] d;
    bit ok;
    host.rd(cmd, d, ok);
    if (!ok) begin
      error_cnt++;
      $display("CHECK FAILED %s read answer expected 1 seen 0", what);
    end
    check16(what, exp, d);
  endtask

  task automatic pulse_telem_series();
    telem = 1'b1;
    series = 1'b1;
    tick();
    telem = 1'b0;
    series = 1'b0;
    tick();
  endtask

  // one measurement strobe on the field behind event bit i
  task automatic apply(input int i, input logic signed [15:0] v);
    meas = '0;
    meas[MPOS[i]*16 +: 16] = v;
    meas_stb = 1'b1;
    tick();
    meas_stb = 1'b0;
    meas = '0;
    tick();
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    for (int i = 0; i < 12; i++) begin
      lim[i*16 +: 16] = ABOVE[i] ? 16'sh0064 : -16'sh0064;
    end
    repeat (16) @(posedge clk);
    #1;
    srst = 1'b0;
    rd_chk(8'h34, 16'h0100, "phase reset");
    rd_chk(8'h35, 16'h0000, "loop reset");
    rd_chk(8'h36, 16'h0000, "event reset");
    rd_chk(8'h37, 16'h0000, "unmapped read");
    host.wr(8'h34, 16'hffff);
    host.wr(8'h35, 16'hffff);
    rd_chk(8'h34, 16'h0100, "phase read only");
    rd_chk(8'h35, 16'h0000, "loop read only");
    for (int k = 0; k < 11; k++) begin
      phase = chsla_phase_t'(k);
      tick();
      tick();
      check16("phase port", {3'h0, CODES[k]}, {3'h0, phase_word});
      rd_chk(8'h34, {3'h0, CODES[k]}, "phase reg");
    end
    phase = ph_normal_charging;
    loop_in = 6'h20;
    tick();
    tick();
    rd_chk(8'h35, 16'h0020, "loop input limit");
    loop_in = 6'h21;
    tick();
    rd_chk(8'h35, 16'h0020, "loop exclusive");
    phase = ph_absorb;
    loop_in = 6'h03;
    tick();
    rd_chk(8'h35, 16'h0002, "loop absorb");
    phase = ph_suspended;
    tick();
    check16("loop not charging", 16'h0000, {10'h000, loop_out});
    rd_chk(8'h35, 16'h0000, "loop not charging reg");
    pulse_telem_series();
    apply(11, -16'sh0065);
    rd_chk(8'h36, 16'h0000, "events disabled");
    alert_en = 16'hffff;
    for (int i = 0; i < 12; i++) begin
      apply(i, ABOVE[i] ? 16'sh0064 : -16'sh0064);
      rd_chk(8'h36, 16'h0000, "limit equal");
      apply(i, ABOVE[i] ? 16'sh0065 : -16'sh0065);
      rd_chk(8'h36, 16'h0001 << i, "limit crossed");
      host.wr(8'h36, ~(16'h0001 << i));
      rd_chk(8'h36, 16'h0000, "limit cleared");
    end
    pulse_telem_series();
    apply(11, -16'sh0065);
    tick();
    rd_chk(8'h36, 16'hc800, "sticky events");
    host.wr(8'h36, 16'hbfff);
    rd_chk(8'h36, 16'h8800, "clear one keep others");
    host.wr(8'h36, 16'hffff);
    rd_chk(8'h36, 16'h8800, "write ones keep");
    alert_en = 16'h7fff;
    tick();
    alert_en = 16'hffff;
    tick();
    check16("disable clears", 16'h0800, event_out);
    host.wr(8'h36, 16'h37ff);
    rd_chk(8'h36, 16'h0000, "unused bits zero");
    phase = ph_absorb;
    pulse_telem_series();
    phase = chsla_phase_t'(4'hf);
    tick();
    check16("illegal phase keeps", {3'h0, `CHSLA_PH_ABSORB}, {3'h0, phase_word});
    srst = 1'b1;
    tick();
    srst = 1'b0;
    rd_chk(8'h36, 16'h0000, "event second reset");
    rd_chk(8'h34, 16'h0100, "phase second reset");
    rd_chk(8'h35, 16'h0000, "loop second reset");
    close_out();
  end
endmodule // charger_state_and_limit_alerts_tb

`default_nettype wire
